// File: fosr_pkg.sv
// package: register indices, slots, state codes and the bus decoder for the status bank
`default_nettype none
package fosr_pkg;
    // bus geometry
    localparam int FOSR_ADDR_W = 16;
    localparam int FOSR_DATA_W = 32;
    localparam int FOSR_SLOTS = 8;
    // register offsets are word indices; the byte address is four times the index
    localparam logic [13:0] FOSR_IDX_STARTUP_SPEED = 14'h068A;
    localparam logic [13:0] FOSR_IDX_PROBE_STATE = 14'h06BE;
    localparam logic [13:0] FOSR_IDX_PROBE_ANGLE = 14'h0702;
    localparam logic [13:0] FOSR_IDX_BEMF_DIRECT = 14'h0748;
    localparam logic [13:0] FOSR_IDX_BEMF_QUAD = 14'h074A;
    localparam logic [13:0] FOSR_IDX_ROTOR_SPEED = 14'h0758;
    localparam logic [13:0] FOSR_IDX_ROTOR_ANGLE = 14'h075C;
    localparam logic [13:0] FOSR_IDX_STARTUP_STATE = 14'h0680;
    // reset value shared by every status word
    localparam logic [31:0] FOSR_RESET_WORD = 32'h0000_0000;
    // 16-bit registers keep their value in the low half
    localparam logic [15:0] FOSR_HALF_ZERO = 16'h0000;
    // axi response codes
    localparam logic [1:0] FOSR_RESP_OKAY = 2'h0;
    localparam logic [1:0] FOSR_RESP_SLVERR = 2'h2;

    // storage slot of each register
    typedef enum logic [2:0] {
        FOSR_SLOT_STARTUP_SPEED = 3'h0,
        FOSR_SLOT_PROBE_STATE = 3'h1,
        FOSR_SLOT_PROBE_ANGLE = 3'h2,
        FOSR_SLOT_BEMF_DIRECT = 3'h3,
        FOSR_SLOT_BEMF_QUAD = 3'h4,
        FOSR_SLOT_ROTOR_SPEED = 3'h5,
        FOSR_SLOT_ROTOR_ANGLE = 3'h6,
        FOSR_SLOT_STARTUP_STATE = 3'h7
    } fosr_slot_t;

    // position-probe sequencer codes
    typedef enum logic [15:0] {
        FOSR_PROBE_INIT = 16'h0000,
        FOSR_PROBE_VECTOR_SETUP = 16'h0001,
        FOSR_PROBE_RUNNING = 16'h0002,
        FOSR_PROBE_SLOW_RISING_CLOCK = 16'h0003,
        FOSR_PROBE_SLOW_FALLING_CLOCK = 16'h0004,
        FOSR_PROBE_AWAIT_CURRENT_DECAY = 16'h0005,
        FOSR_PROBE_CAPTURE_TIMES = 16'h0006,
        FOSR_PROBE_NEXT_VECTOR = 16'h0007,
        FOSR_PROBE_SECTOR_RISE_CALC = 16'h0008,
        FOSR_PROBE_ROTOR_POSITION_CALC = 16'h0009,
        FOSR_PROBE_ANGLE_CALC = 16'h000A,
        FOSR_PROBE_DONE = 16'h000B,
        FOSR_PROBE_FAILED = 16'h000C
    } fosr_probe_state_t;

    // initial speed detection codes
    typedef enum logic [15:0] {
        FOSR_DETECT_INIT = 16'h0000,
        FOSR_DETECT_STOP_CHECK = 16'h0001,
        FOSR_DETECT_DIRECTION_CHECK = 16'h0002,
        FOSR_DETECT_DONE = 16'h0003,
        FOSR_DETECT_FAILED = 16'h0004
    } fosr_detect_state_t;

    // one result word from the control engine
    typedef struct packed {
        logic we;
        fosr_slot_t slot;
        logic [31:0] value;
    } fosr_engine_upd_t;

    // decoder answer
    typedef struct packed {
        logic hit;
        fosr_slot_t slot;
    } fosr_dec_t;

    // byte address to slot; misaligned or unknown addresses miss
    function automatic fosr_dec_t fosr_decode(input logic [15:0] addr);
        fosr_dec_t d;
        d.hit = (addr[1:0] == 2'h0);
        d.slot = FOSR_SLOT_STARTUP_SPEED;
        case (addr[15:2])
            FOSR_IDX_STARTUP_SPEED: d.slot = FOSR_SLOT_STARTUP_SPEED;
            FOSR_IDX_PROBE_STATE: d.slot = FOSR_SLOT_PROBE_STATE;
            FOSR_IDX_PROBE_ANGLE: d.slot = FOSR_SLOT_PROBE_ANGLE;
            FOSR_IDX_BEMF_DIRECT: d.slot = FOSR_SLOT_BEMF_DIRECT;
            FOSR_IDX_BEMF_QUAD: d.slot = FOSR_SLOT_BEMF_QUAD;
            FOSR_IDX_ROTOR_SPEED: d.slot = FOSR_SLOT_ROTOR_SPEED;
            FOSR_IDX_ROTOR_ANGLE: d.slot = FOSR_SLOT_ROTOR_ANGLE;
            FOSR_IDX_STARTUP_STATE: d.slot = FOSR_SLOT_STARTUP_STATE;
            default: d.hit = 1'b0;
        endcase
        return d;
    endfunction : fosr_decode
endpackage : fosr_pkg
`default_nettype wire

// File: fosr_status_mem.sv
// eight-word status store: engine write port, registered read port
`default_nettype none
module fosr_status_mem (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic we,
    input wire fosr_pkg::fosr_slot_t wr_slot,
    input wire logic [31:0] wr_data,
    input wire logic rd_en,
    input wire fosr_pkg::fosr_slot_t rd_slot,
    output logic [31:0] rd_data
);
    // storage words, all cleared by reset
    logic [31:0] words [fosr_pkg::FOSR_SLOTS];

    // engine writes; the bus has no path in here at all
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < fosr_pkg::FOSR_SLOTS; i++) begin
                words[i] <= fosr_pkg::FOSR_RESET_WORD;
            end
        end else if (we) begin
            words[wr_slot] <= wr_data;
        end
    end

    // read before write: a same-edge update shows on the next read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_data <= fosr_pkg::FOSR_RESET_WORD;
        end else if (rd_en) begin
            rd_data <= words[rd_slot];
        end
    end

    // a value written by the engine is returned by the next read of its slot
    property p_write_then_read(fosr_pkg::fosr_slot_t s);
        @(posedge core_clk) disable iff (rst)
        (we && wr_slot == s) ##1 (rd_en && rd_slot == s && !(we && wr_slot == s))
        |=> rd_data == $past(wr_data, 2);
    endproperty

    AST_STARTUP_SPEED_RD: assert property (p_write_then_read(fosr_pkg::FOSR_SLOT_STARTUP_SPEED))
        else $error("startup speed read differs from engine value");
    AST_BEMF_D_RD: assert property (p_write_then_read(fosr_pkg::FOSR_SLOT_BEMF_DIRECT))
        else $error("d-axis back-emf read differs from engine value");
    AST_BEMF_Q_RD: assert property (p_write_then_read(fosr_pkg::FOSR_SLOT_BEMF_QUAD))
        else $error("q-axis back-emf read differs from engine value");
    AST_ROTOR_SPEED_RD: assert property (p_write_then_read(fosr_pkg::FOSR_SLOT_ROTOR_SPEED))
        else $error("rotor speed read differs from engine value");
    AST_ROTOR_ANGLE_RD: assert property (p_write_then_read(fosr_pkg::FOSR_SLOT_ROTOR_ANGLE))
        else $error("rotor angle read differs from engine value");
    // a read must leave the word it returned untouched
    AST_READ_STABLE: assert property (
        @(posedge core_clk) disable iff (rst)
        (rd_en && !we) |=> rd_data == words[$past(rd_slot)])
        else $error("read changed the word it returned");
endmodule : fosr_status_mem
`default_nettype wire

// File: fosr_write_sink.sv
// axi4-lite write channels: accepted, answered, never stored
`default_nettype none
module fosr_write_sink (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic [15:0] s_axi_awaddr,
    output logic s_axi_awready,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp
);
    logic aw_hs; // address taken this edge
    logic w_hs; // data taken this edge
    logic aw_seen; // address held until response
    logic w_seen; // data held until response
    logic b_hs; // response accepted
    fosr_pkg::fosr_dec_t dec;

    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign b_hs = s_axi_bvalid && s_axi_bready;
    assign dec = fosr_pkg::fosr_decode(s_axi_awaddr);

    // channel flags; one write in flight at a time
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_seen <= 1'b0;
            w_seen <= 1'b0;
        end else if (b_hs) begin
            aw_seen <= 1'b0;
            w_seen <= 1'b0;
        end else begin
            aw_seen <= aw_seen || aw_hs;
            w_seen <= w_seen || w_hs;
        end
    end

    // readies drop once their item is in and return after the response
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_seen && !aw_hs && !s_axi_bvalid;
            s_axi_wready <= !w_seen && !w_hs && !s_axi_bvalid;
        end
    end

    // response: known register answers okay and is ignored, others slverr
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fosr_pkg::FOSR_RESP_OKAY;
        end else if (b_hs) begin
            s_axi_bvalid <= 1'b0;
        end else if (!s_axi_bvalid && (aw_seen || aw_hs) && (w_seen || w_hs)) begin
            s_axi_bvalid <= 1'b1;
        end
        if (!rst && aw_hs) begin
            s_axi_bresp <= dec.hit ? fosr_pkg::FOSR_RESP_OKAY : fosr_pkg::FOSR_RESP_SLVERR;
        end
    end

    AST_WR_ANSWER: assert property (
        @(posedge core_clk) disable iff (rst)
        (aw_hs && w_hs) |=> s_axi_bvalid)
        else $error("write response did not follow address and data");
    COV_WRITE: cover property (@(posedge core_clk) disable iff (rst) b_hs);
endmodule : fosr_write_sink
`default_nettype wire

// File: fosr_status_top.sv
// status register bank for the sensorless control engine, read over axi4-lite
// Overview of operation
// - startup speed estimate, read-only 32-bit word
// - probe state, read-only 16-bit, resets zero
// - probe state codes zero through C
// - probe angle, read-only 32-bit, resets zero
// - d-axis back-emf, read-only 32-bit word
// - q-axis back-emf, read-only 32-bit word
// - rotor speed estimate, read-only 32-bit word
// - rotor angle estimate, read-only 32-bit word
// - startup detect state codes zero through four
`default_nettype none
module fosr_status_top (
    input wire logic core_clk,
    input wire logic rst,
    // engine result port
    input wire fosr_pkg::fosr_engine_upd_t engine_upd,
    // axi4-lite write channels
    input wire logic s_axi_awvalid,
    input wire logic [15:0] s_axi_awaddr,
    output logic s_axi_awready,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read channels
    input wire logic s_axi_arvalid,
    input wire logic [15:0] s_axi_araddr,
    output logic s_axi_arready,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    // read sequencer, gray along idle -> fetch -> respond
    typedef enum logic [1:0] {
        FOSR_RD_IDLE = 2'b00,
        FOSR_RD_FETCH = 2'b01,
        FOSR_RD_RESP = 2'b11
    } fosr_rd_state_t;

    fosr_rd_state_t rd_state; // current read phase
    fosr_rd_state_t next_rd_state; // phase after this edge
    logic ar_hs; // read address taken
    logic r_hs; // read data taken
    fosr_pkg::fosr_dec_t ar_dec; // decode of the offered read address
    logic rd_hit; // latched hit of the read in flight
    fosr_pkg::fosr_slot_t rd_slot; // latched slot of the read in flight
    logic [31:0] mem_rd_data; // store output, valid in fetch
    logic [31:0] next_wr_value; // engine value after range clean-up
    logic angle_untouched; // no engine write to the probe angle since reset

    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign r_hs = s_axi_rvalid && s_axi_rready;
    assign ar_dec = fosr_pkg::fosr_decode(s_axi_araddr);

    // engine values: half-width registers and state codes are cleaned up
    // here so that software never sees a code outside the documented set
    always_comb begin
        next_wr_value = engine_upd.value;
        case (engine_upd.slot)
            fosr_pkg::FOSR_SLOT_PROBE_STATE: begin
                // unknown sequencer codes are reported as a fault
                if (engine_upd.value[15:0] > fosr_pkg::FOSR_PROBE_FAILED) begin
                    next_wr_value = {fosr_pkg::FOSR_HALF_ZERO, fosr_pkg::FOSR_PROBE_FAILED};
                end else begin
                    next_wr_value = {fosr_pkg::FOSR_HALF_ZERO, engine_upd.value[15:0]};
                end
            end
            fosr_pkg::FOSR_SLOT_STARTUP_STATE: begin
                // same treatment for the speed-detection sequencer
                if (engine_upd.value[15:0] > fosr_pkg::FOSR_DETECT_FAILED) begin
                    next_wr_value = {fosr_pkg::FOSR_HALF_ZERO, fosr_pkg::FOSR_DETECT_FAILED};
                end else begin
                    next_wr_value = {fosr_pkg::FOSR_HALF_ZERO, engine_upd.value[15:0]};
                end
            end
            default: begin
                // full-width fixed-point words pass as they are
                next_wr_value = engine_upd.value;
            end
        endcase
    end

    // result store; only the engine writes it, the bus only reads it
    fosr_status_mem u_mem (
        .core_clk(core_clk),
        .rst(rst),
        .we(engine_upd.we),
        .wr_slot(engine_upd.slot),
        .wr_data(next_wr_value),
        .rd_en(ar_hs),
        .rd_slot(ar_dec.slot),
        .rd_data(mem_rd_data)
    );

    // write side: answered but never stored
    fosr_write_sink u_wsink (
        .core_clk(core_clk),
        .rst(rst),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awready(s_axi_awready),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp)
    );

    // read phase selection
    always_comb begin
        next_rd_state = rd_state;
        case (rd_state)
            FOSR_RD_IDLE: begin
                if (ar_hs) begin
                    next_rd_state = FOSR_RD_FETCH;
                end
            end
            FOSR_RD_FETCH: begin
                // store data is ready one edge after the address
                next_rd_state = FOSR_RD_RESP;
            end
            FOSR_RD_RESP: begin
                if (r_hs) begin
                    next_rd_state = FOSR_RD_IDLE;
                end
            end
            default: begin
                next_rd_state = FOSR_RD_IDLE;
            end
        endcase
    end

    // read phase register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_state <= FOSR_RD_IDLE;
        end else begin
            rd_state <= next_rd_state;
        end
    end

    // address ready only while idle; one read in flight keeps ordering simple
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= (next_rd_state == FOSR_RD_IDLE);
        end
    end

    // latch what the read in flight is aimed at
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_hit <= 1'b0;
            rd_slot <= fosr_pkg::FOSR_SLOT_STARTUP_SPEED;
        end else if (ar_hs) begin
            rd_hit <= ar_dec.hit;
            rd_slot <= ar_dec.slot;
        end
    end

    // read answer; reads have no side effect on the store
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= fosr_pkg::FOSR_RESET_WORD;
            s_axi_rresp <= fosr_pkg::FOSR_RESP_OKAY;
        end else if (rd_state == FOSR_RD_FETCH) begin
            s_axi_rvalid <= 1'b1;
            // unmapped reads return zero so stale data never leaks
            s_axi_rdata <= rd_hit ? mem_rd_data : fosr_pkg::FOSR_RESET_WORD;
            s_axi_rresp <= rd_hit ? fosr_pkg::FOSR_RESP_OKAY : fosr_pkg::FOSR_RESP_SLVERR;
        end else if (r_hs) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // check helper: set by reset, cleared by the first engine angle write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            angle_untouched <= 1'b1;
        end else if (engine_upd.we && engine_upd.slot == fosr_pkg::FOSR_SLOT_PROBE_ANGLE) begin
            angle_untouched <= 1'b0;
        end
    end

    // checks on the bus-visible answer
    AST_PROBE_STATE_HALF: assert property (
        @(posedge core_clk) disable iff (rst)
        (s_axi_rvalid && rd_hit && rd_slot == fosr_pkg::FOSR_SLOT_PROBE_STATE)
        |-> s_axi_rdata[31:16] == fosr_pkg::FOSR_HALF_ZERO)
        else $error("probe state upper half not zero");
    AST_PROBE_STATE_CODE: assert property (
        @(posedge core_clk) disable iff (rst)
        (s_axi_rvalid && rd_hit && rd_slot == fosr_pkg::FOSR_SLOT_PROBE_STATE)
        |-> s_axi_rdata[15:0] <= 16'h000C)
        else $error("probe state code out of range");
    AST_PROBE_ANGLE_RESET: assert property (
        @(posedge core_clk) disable iff (rst)
        (s_axi_rvalid && rd_hit && rd_slot == fosr_pkg::FOSR_SLOT_PROBE_ANGLE
        && angle_untouched)
        |-> s_axi_rdata == fosr_pkg::FOSR_RESET_WORD)
        else $error("probe angle not zero after reset");
    AST_DETECT_STATE_CODE: assert property (
        @(posedge core_clk) disable iff (rst)
        (s_axi_rvalid && rd_hit && rd_slot == fosr_pkg::FOSR_SLOT_STARTUP_STATE)
        |-> s_axi_rdata <= 32'h0000_0004)
        else $error("startup detect state code out of range");
    AST_READ_LATENCY: assert property (
        @(posedge core_clk) disable iff (rst)
        ar_hs |=> !s_axi_rvalid ##1 (s_axi_rvalid && !s_axi_arready))
        else $error("read answer not two edges after address");
    AST_UNMAPPED_READ: assert property (
        @(posedge core_clk) disable iff (rst)
        (ar_hs && !ar_dec.hit) |-> ##2 (s_axi_rresp == fosr_pkg::FOSR_RESP_SLVERR))
        else $error("unmapped read not answered with slverr");

    COV_READ_HIT: cover property (@(posedge core_clk) disable iff (rst) r_hs && rd_hit);
    COV_READ_MISS: cover property (@(posedge core_clk) disable iff (rst) r_hs && !rd_hit);
    COV_PROBE_FAULT: cover property (@(posedge core_clk) disable iff (rst)
        engine_upd.we && engine_upd.slot == fosr_pkg::FOSR_SLOT_PROBE_STATE
        && engine_upd.value[15:0] > 16'h000C);
endmodule : fosr_status_top
`default_nettype wire

// File: fosr_status_top_tb.sv
// self-checking bench for the status register bank over axi4-lite
`default_nettype none
module fosr_status_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0; // 125 MHz
    logic rst = 1'b1; // synchronous, active high
    fosr_pkg::fosr_engine_upd_t engine_upd = '0; // engine result port
    logic s_axi_awvalid = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000;
    logic s_axi_awready;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [1:0] s_axi_bresp;
    logic s_axi_arvalid = 1'b0;
    logic [15:0] s_axi_araddr = 16'h0000;
    logic s_axi_arready;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    int mismatches = 0; // failed comparisons
    int check_count = 0; // all comparisons
    logic [31:0] rd; // last read word
    logic [1:0] rs; // last response code
    logic [31:0] shadow [8]; // expected content of each slot

    always #4 core_clk = ~core_clk;

    fosr_status_top dut (
        .core_clk(core_clk), .rst(rst), .engine_upd(engine_upd),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_araddr(s_axi_araddr),
        .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
    );

    // verdict and end of run, reached from every exit
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // single comparison point
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // byte address of a slot: the register offset is a word index
    function automatic logic [15:0] addr_of(input int s);
        logic [13:0] idx;
        case (s)
            0: idx = fosr_pkg::FOSR_IDX_STARTUP_SPEED;
            1: idx = fosr_pkg::FOSR_IDX_PROBE_STATE;
            2: idx = fosr_pkg::FOSR_IDX_PROBE_ANGLE;
            3: idx = fosr_pkg::FOSR_IDX_BEMF_DIRECT;
            4: idx = fosr_pkg::FOSR_IDX_BEMF_QUAD;
            5: idx = fosr_pkg::FOSR_IDX_ROTOR_SPEED;
            6: idx = fosr_pkg::FOSR_IDX_ROTOR_ANGLE;
            default: idx = fosr_pkg::FOSR_IDX_STARTUP_STATE;
        endcase
        return {idx, 2'h0};
    endfunction : addr_of

    // what a slot holds after the engine writes v: 16-bit codes clamp to their fault code
    function automatic logic [31:0] stored(input int s, input logic [31:0] v);
        if (s == 1) begin
            return (v[15:0] > 16'h000C) ? 32'h0000_000C : {16'h0000, v[15:0]};
        end
        if (s == 7) begin
            return (v[15:0] > 16'h0004) ? 32'h0000_0004 : {16'h0000, v[15:0]};
        end
        return v;
    endfunction : stored

    // one axi4-lite read offered at once; request held until each channel is taken
    task automatic axi_read_now(input logic [15:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        mismatches++;
        $display("unexpected read timeout expected answer seen none");
        wrap_up();
    endtask : axi_read_now

    // one axi4-lite read, offered one edge after the call
    task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        axi_read_now(a, d, r);
    endtask : axi_read

    // one axi4-lite write; address and data offered together, no data port exists
    task automatic axi_write(input logic [15:0] a, output logic [1:0] r);
        int n;
        @(posedge core_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        mismatches++;
        $display("unexpected write timeout expected answer seen none");
        wrap_up();
    endtask : axi_write

    // engine result for one edge, then the strobe drops
    task automatic eng_put(input int s, input logic [31:0] v);
        @(posedge core_clk);
        engine_upd <= {1'b1, 3'(s), v};
        @(posedge core_clk);
        engine_upd <= {1'b0, 3'(s), v};
        shadow[s] = stored(s, v);
    endtask : eng_put

    // read every slot and compare with the shadow copy
    task automatic read_all(input string what);
        for (int s = 0; s < 8; s++) begin
            axi_read(addr_of(s), rd, rs);
            check(what, rd, shadow[s]);
            check("read response", 32'(rs), 32'(fosr_pkg::FOSR_RESP_OKAY));
        end
    endtask : read_all

    // main sequence
    initial begin
        for (int s = 0; s < 8; s++) begin
            shadow[s] = fosr_pkg::FOSR_RESET_WORD;
        end
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        // reset values of every status word
        read_all("reset value");
        $display("test reset values done");
        // full-width patterns; upper half of 16-bit words must read zero
        // each word read back on the edge right after the engine stores it
        for (int s = 0; s < 8; s++) begin
            eng_put(s, 32'hFFFF_FFF0 ^ 32'(s));
            axi_read_now(addr_of(s), rd, rs);
            check("read after store", rd, shadow[s]);
        end
        read_all("all ones pattern");
        for (int s = 0; s < 8; s++) begin
            eng_put(s, 32'h8000_0001 + 32'(s << 4));
        end
        read_all("latest value");
        read_all("second read");
        $display("test engine values done");
        // every probe sequencer code, then one past the fault code
        for (int c = 0; c <= 13; c++) begin
            eng_put(1, 32'(c));
            axi_read(addr_of(1), rd, rs);
            check("probe state code", rd, stored(1, 32'(c)));
        end
        // every startup detection code, then one past the fault code
        for (int c = 0; c <= 5; c++) begin
            eng_put(7, 32'(c));
            axi_read(addr_of(7), rd, rs);
            check("detect state code", rd, stored(7, 32'(c)));
        end
        $display("test state codes done");
        // host writes answer but change nothing
        for (int s = 0; s < 8; s++) begin
            axi_write(addr_of(s), rs);
            check("write response", 32'(rs), 32'(fosr_pkg::FOSR_RESP_OKAY));
        end
        axi_write(16'h1A2C, rs);
        check("unmapped write response", 32'(rs), 32'(fosr_pkg::FOSR_RESP_SLVERR));
        read_all("after host write");
        $display("test host writes done");
        // unmapped and misaligned reads
        axi_read(16'h1A2C, rd, rs);
        check("unmapped read data", rd, 32'h0000_0000);
        check("unmapped read response", 32'(rs), 32'(fosr_pkg::FOSR_RESP_SLVERR));
        axi_read(addr_of(0) + 16'h0002, rd, rs);
        check("misaligned read response", 32'(rs), 32'(fosr_pkg::FOSR_RESP_SLVERR));
        $display("test bad addresses done");
        // second reset in mid-run clears every word
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        for (int s = 0; s < 8; s++) begin
            shadow[s] = fosr_pkg::FOSR_RESET_WORD;
        end
        read_all("value after reset");
        $display("test second reset done");
        wrap_up();
    end
endmodule : fosr_status_top_tb
`default_nettype wire
